// ---- hdl/sspf_regs.svh ----
`ifndef SSPF_REGS_SVH
`define SSPF_REGS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses, low address byte)
// ------------------------------------------------------------
`define SSPF_EVENT_OFS 8'h00
`define SSPF_MASK_OFS 8'h04
`define SSPF_PRESENT_OFS 8'h08
`define SSPF_FORCE_OFS 8'h0C
`define SSPF_CONTROL_OFS 8'h10

// ------------------------------------------------------------
// Present-state and force field positions
// ------------------------------------------------------------
`define SSPF_BIT_REINTERROGATE 14
`define SSPF_VCAP_HI 13
`define SSPF_VCAP_LO 10
`define SSPF_BIT_BAD_SUPPLY 9
`define SSPF_BIT_REMOVAL_LOSS 8
`define SSPF_BIT_UNRECOGNIZED 7
`define SSPF_BIT_CARD_IRQ 6
`define SSPF_BIT_CARDBUS 5
`define SSPF_BIT_LEGACY16 4
`define SSPF_BIT_POWERED 3
`define SSPF_BIT_DETECT_B 2
`define SSPF_BIT_DETECT_A 1
`define SSPF_BIT_STATUS_CHANGE 0

// ------------------------------------------------------------
// Event/mask layout and control fields
// ------------------------------------------------------------
`define SSPF_EV_POWER 3
`define SSPF_EV_DETECT_B 2
`define SSPF_EV_DETECT_A 1
`define SSPF_EV_STATUS 0
`define SSPF_CTRL_VCC_HI 6
`define SSPF_CTRL_VCC_LO 4
`define SSPF_CTRL_VPP_HI 2
`define SSPF_CTRL_VPP_LO 0
`define SSPF_DETECT_MASK_ON 2'h3

// ------------------------------------------------------------
// Supply request codes, reset values, timing
// ------------------------------------------------------------
`define SSPF_VCC_OFF 3'h0
`define SSPF_VCC_5V 3'h2
`define SSPF_VCC_3V 3'h3
`define SSPF_VCC_XV 3'h4
`define SSPF_VCC_YV 3'h5
`define SSPF_EVENT_RST 4'h0
`define SSPF_MASK_RST 4'h0
`define SSPF_CONTROL_RST 6'h00
`define SSPF_VCAP_RST 4'h0
`define SSPF_PROBE_CYCLES 16

`endif

// ---- hdl/sspf_pkg.sv ----
package sspf_pkg;

    typedef enum logic [1:0] {
        SSPF_IDLE = 2'b00,
        SSPF_PROBE = 2'b01,
        SSPF_LATCH = 2'b10
    } sspf_probe_state_type;

endpackage

// ---- hdl/sspf_socket_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sspf_regs.svh"

module sspf_socket_regs
    import sspf_pkg::*;
#(
    parameter int PROBE_CYCLES = `SSPF_PROBE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic global_reset_n,
    input wire logic wake_event_enable,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic card_detect_a_pin,
    input wire logic card_detect_b_pin,
    input wire logic card_status_change_pin,
    input wire logic card_irq_pin,
    input wire logic probe_cardbus,
    input wire logic probe_legacy16,
    input wire logic [3:0] probe_volt_caps,
    input wire logic removal_cycle_pending,
    output logic socket_change_interrupt,
    output logic socket_power_on,
    output logic socket_power_auto
);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic addr_phase;
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic wr_event, wr_mask, wr_force, wr_control;
    logic [31:0] read_value;
    logic ctx_rst_n;

    assign addr_phase = hsel && hready && htrans[1];
    assign wr_event = wr_pend_reg && (addr_reg == `SSPF_EVENT_OFS);
    assign wr_mask = wr_pend_reg && (addr_reg == `SSPF_MASK_OFS);
    assign wr_force = wr_pend_reg && (addr_reg == `SSPF_FORCE_OFS);
    assign wr_control = wr_pend_reg && (addr_reg == `SSPF_CONTROL_OFS);
    // Context reset survives a bus reset while wake events are enabled
    assign ctx_rst_n = global_reset_n && (hresetn || wake_event_enable);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                addr_reg <= haddr[7:0];
            end
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrogation sequencer
    // ------------------------------------------------------------
    sspf_probe_state_type state_reg;
    logic [15:0] probe_cnt_reg;
    logic card_in, card_in_d_reg, probing, probe_done, reinterrogate;

    assign card_in = !card_detect_a_pin && !card_detect_b_pin;
    assign probing = (state_reg != SSPF_IDLE);
    assign probe_done = (state_reg == SSPF_LATCH);
    assign reinterrogate = wr_force && hwdata[`SSPF_BIT_REINTERROGATE];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= SSPF_IDLE;
            probe_cnt_reg <= 16'h0000;
            card_in_d_reg <= 1'b0;
        end else begin
            card_in_d_reg <= card_in;
            case (state_reg)
                SSPF_IDLE: begin
                    probe_cnt_reg <= 16'h0000;
                    if ((card_in && !card_in_d_reg) || reinterrogate) begin
                        state_reg <= SSPF_PROBE;
                    end
                end
                SSPF_PROBE: begin
                    probe_cnt_reg <= probe_cnt_reg + 16'h0001;
                    if (probe_cnt_reg == 16'(PROBE_CYCLES - 1)) begin
                        state_reg <= SSPF_LATCH;
                    end
                end
                SSPF_LATCH: begin
                    state_reg <= SSPF_IDLE;
                end
                default: begin
                    state_reg <= SSPF_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Socket control and supply checking
    // ------------------------------------------------------------
    logic [2:0] vcc_reg, vpp_reg;
    logic [3:0] volt_caps_reg;
    logic auto_power_reg, bad_supply_request_flag_reg, socket_powered_flag_reg;
    logic [2:0] vcc_new;
    logic vcc_invalid;

    assign vcc_new = hwdata[`SSPF_CTRL_VCC_HI:`SSPF_CTRL_VCC_LO];
    // Socket never supplies X.X or Y.Y volts; caps are checked only under auto control
    always_comb begin
        case (vcc_new)
            `SSPF_VCC_OFF: vcc_invalid = 1'b0;
            `SSPF_VCC_5V: vcc_invalid = auto_power_reg && !volt_caps_reg[0];
            `SSPF_VCC_3V: vcc_invalid = auto_power_reg && !volt_caps_reg[1];
            default: vcc_invalid = 1'b1;
        endcase
    end

    always_ff @(posedge hclk or negedge ctx_rst_n) begin
        if (!ctx_rst_n) begin
            {vcc_reg, vpp_reg} <= `SSPF_CONTROL_RST;
            auto_power_reg <= 1'b1;
            bad_supply_request_flag_reg <= 1'b0;
            socket_powered_flag_reg <= 1'b0;
        end else begin
            if (wr_control) begin
                vpp_reg <= hwdata[`SSPF_CTRL_VPP_HI:`SSPF_CTRL_VPP_LO];
                if (vcc_invalid) begin
                    bad_supply_request_flag_reg <= 1'b1;
                end else begin
                    vcc_reg <= vcc_new;
                    bad_supply_request_flag_reg <= 1'b0;
                end
            end else if (wr_force) begin
                bad_supply_request_flag_reg <= hwdata[`SSPF_BIT_BAD_SUPPLY];
            end
            if (reinterrogate) begin
                auto_power_reg <= 1'b1;
            end else if (wr_force && (|hwdata[`SSPF_VCAP_HI:`SSPF_VCAP_LO])) begin
                auto_power_reg <= 1'b0;
            end
            socket_powered_flag_reg <= (vcc_reg != `SSPF_VCC_OFF);
        end
    end

    // ------------------------------------------------------------
    // Card type, capability and detect state
    // ------------------------------------------------------------
    logic cardbus_type_flag_reg, legacy16_type_flag_reg, unrecognized_card_flag_reg;
    logic removal_loss_flag_reg, detect_a_level_reg, detect_b_level_reg;
    logic removal, change_a, change_b;

    assign change_a = !probing && (card_detect_a_pin != detect_a_level_reg);
    assign change_b = !probing && (card_detect_b_pin != detect_b_level_reg);
    assign removal = (change_a && card_detect_a_pin) || (change_b && card_detect_b_pin);

    always_ff @(posedge hclk or negedge ctx_rst_n) begin
        if (!ctx_rst_n) begin
            volt_caps_reg <= `SSPF_VCAP_RST;
            cardbus_type_flag_reg <= 1'b0;
            legacy16_type_flag_reg <= 1'b0;
            unrecognized_card_flag_reg <= 1'b0;
            removal_loss_flag_reg <= 1'b0;
            detect_a_level_reg <= 1'b1;
            detect_b_level_reg <= 1'b1;
        end else begin
            // Pin changes while probing stay hidden
            if (!probing) begin
                detect_a_level_reg <= card_detect_a_pin;
                detect_b_level_reg <= card_detect_b_pin;
            end
            if (wr_force) begin
                volt_caps_reg <= hwdata[`SSPF_VCAP_HI:`SSPF_VCAP_LO];
                cardbus_type_flag_reg <= hwdata[`SSPF_BIT_CARDBUS];
                legacy16_type_flag_reg <= hwdata[`SSPF_BIT_LEGACY16];
                unrecognized_card_flag_reg <= hwdata[`SSPF_BIT_UNRECOGNIZED];
                removal_loss_flag_reg <= hwdata[`SSPF_BIT_REMOVAL_LOSS];
            end else if (probe_done) begin
                volt_caps_reg <= probe_volt_caps;
                cardbus_type_flag_reg <= probe_cardbus;
                legacy16_type_flag_reg <= probe_legacy16;
                unrecognized_card_flag_reg <= !probe_cardbus && !probe_legacy16;
                removal_loss_flag_reg <= 1'b0;
            end else if (removal && removal_cycle_pending) begin
                removal_loss_flag_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Event, mask and interrupt
    // ------------------------------------------------------------
    logic [3:0] event_reg, mask_reg, hw_set, force_set, int_enable;
    logic status_d_reg, powered_d_reg;

    assign hw_set = {socket_powered_flag_reg != powered_d_reg, change_b, change_a,
                     card_status_change_pin && !status_d_reg};
    assign force_set = wr_force ? hwdata[3:0] : 4'h0;
    assign int_enable = {mask_reg[`SSPF_EV_POWER],
                         {2{mask_reg[2:1] == `SSPF_DETECT_MASK_ON}},
                         mask_reg[`SSPF_EV_STATUS]};

    always_ff @(posedge hclk or negedge ctx_rst_n) begin
        if (!ctx_rst_n) begin
            event_reg <= `SSPF_EVENT_RST;
            mask_reg <= `SSPF_MASK_RST;
            status_d_reg <= 1'b0;
            powered_d_reg <= 1'b0;
        end else begin
            status_d_reg <= card_status_change_pin;
            powered_d_reg <= socket_powered_flag_reg;
            if (wr_mask) begin
                mask_reg <= hwdata[3:0];
            end
            // New events win over a simultaneous write-one clear
            event_reg <= (event_reg & ~(wr_event ? hwdata[3:0] : 4'h0))
                         | hw_set | force_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            socket_change_interrupt <= 1'b0;
            socket_power_on <= 1'b0;
            socket_power_auto <= 1'b1;
        end else begin
            socket_change_interrupt <= |(event_reg & int_enable);
            socket_power_on <= socket_powered_flag_reg;
            socket_power_auto <= auto_power_reg;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        read_value = 32'h0000_0000;
        case (haddr[7:0])
            `SSPF_EVENT_OFS: read_value[3:0] = event_reg;
            `SSPF_MASK_OFS: read_value[3:0] = mask_reg;
            `SSPF_PRESENT_OFS: begin
                read_value[`SSPF_VCAP_HI:`SSPF_VCAP_LO] = volt_caps_reg;
                read_value[`SSPF_BIT_BAD_SUPPLY] = bad_supply_request_flag_reg;
                read_value[`SSPF_BIT_REMOVAL_LOSS] = removal_loss_flag_reg;
                read_value[`SSPF_BIT_UNRECOGNIZED] = unrecognized_card_flag_reg;
                read_value[`SSPF_BIT_CARD_IRQ] = card_irq_pin;
                read_value[`SSPF_BIT_CARDBUS] = cardbus_type_flag_reg;
                read_value[`SSPF_BIT_LEGACY16] = legacy16_type_flag_reg;
                read_value[`SSPF_BIT_POWERED] = socket_powered_flag_reg;
                read_value[`SSPF_BIT_DETECT_B] = detect_b_level_reg;
                read_value[`SSPF_BIT_DETECT_A] = detect_a_level_reg;
                read_value[`SSPF_BIT_STATUS_CHANGE] = card_status_change_pin;
            end
            `SSPF_CONTROL_OFS: begin
                read_value[`SSPF_CTRL_VCC_HI:`SSPF_CTRL_VCC_LO] = vcc_reg;
                read_value[`SSPF_CTRL_VPP_HI:`SSPF_CTRL_VPP_LO] = vpp_reg;
            end
            default: read_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= read_value;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || !global_reset_n);

    property p_bad_supply;
        wr_control && (vcc_new == `SSPF_VCC_XV) |=> bad_supply_request_flag_reg;
    endproperty
    a_bad_supply: assert property (p_bad_supply) else $error("bad supply flag not set");

    property p_removal_loss;
        removal && removal_cycle_pending && !wr_force && !probe_done |=> removal_loss_flag_reg;
    endproperty
    a_removal_loss: assert property (p_removal_loss) else $error("removal loss missed");

    property p_type_stable;
        !wr_force && !probe_done |=> $stable({unrecognized_card_flag_reg,
                                              cardbus_type_flag_reg, legacy16_type_flag_reg});
    endproperty
    a_type_stable: assert property (p_type_stable) else $error("type flag moved");

    property p_live_pins;
        addr_phase && !hwrite && (haddr[7:0] == `SSPF_PRESENT_OFS) |=>
            hrdata[6] == $past(card_irq_pin) && hrdata[0] == $past(card_status_change_pin);
    endproperty
    a_live_pins: assert property (p_live_pins) else $error("live pin bits wrong");

    property p_power_state;
        ##1 socket_powered_flag_reg == ($past(vcc_reg) != `SSPF_VCC_OFF);
    endproperty
    a_power_state: assert property (p_power_state) else $error("power flag wrong");

    property p_detect_frozen;
        probing |=> $stable({detect_a_level_reg, detect_b_level_reg});
    endproperty
    a_detect_frozen: assert property (p_detect_frozen) else $error("detect moved");

    property p_reinterrogate;
        reinterrogate && (state_reg == SSPF_IDLE) |=> probing && auto_power_reg [*2];
    endproperty
    a_reinterrogate: assert property (p_reinterrogate) else $error("no reprobe");

    property p_force_caps;
        wr_force && !reinterrogate && (|hwdata[13:10]) |=>
            !auto_power_reg && volt_caps_reg == $past(hwdata[13:10]);
    endproperty
    a_force_caps: assert property (p_force_caps) else $error("force caps failed");

    property p_force_event;
        wr_force && hwdata[3] |=> event_reg[3] && $stable(socket_powered_flag_reg);
    endproperty
    a_force_event: assert property (p_force_event) else $error("force event failed");

    property p_force_reads_zero;
        addr_phase && !hwrite && (haddr[7:0] == `SSPF_FORCE_OFS) |=> hrdata == 32'h0000_0000;
    endproperty
    a_force_reads_zero: assert property (p_force_reads_zero) else $error("force nonzero");

    property p_detect_masked;
        (mask_reg == 4'h0) [*2] |=> !socket_change_interrupt;
    endproperty
    a_detect_masked: assert property (p_detect_masked) else $error("masked irq seen");

    c_probe_done: cover property (probe_done);
    c_irq: cover property (socket_change_interrupt);
    c_force_then_read: cover property (wr_force ##1 addr_phase && !hwrite);
    c_removal_loss: cover property (removal && removal_cycle_pending);

endmodule

`default_nettype wire

// ---- verification/sspf_card_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Card in the socket
// ------------------------------------------------------------
module sspf_card_model (
    input wire logic inserted,
    input wire logic glitch_b,
    input wire logic [1:0] kind,
    input wire logic [3:0] caps,
    output logic detect_a_n,
    output logic detect_b_n,
    output logic cardbus,
    output logic legacy16,
    output logic [3:0] volt_caps
);
    // Detect pins pulled up while the socket is empty
    assign detect_a_n = ~inserted;
    // Contact bounce on one detect pin, driven on request only
    assign detect_b_n = ~inserted | glitch_b;
    // An empty socket answers no type and no capability
    assign cardbus = inserted & kind[1];
    assign legacy16 = inserted & kind[0];
    assign volt_caps = inserted ? caps : 4'h0;
endmodule

`default_nettype wire

// ---- verification/sspf_socket_regs_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sspf_regs.svh"

module sspf_socket_regs_tb_top;
    localparam int PROBE = 8;
    logic hclk, hresetn, global_reset_n, wake_event_enable;
    logic [31:0] haddr, hwdata, hrdata, rd, v;
    logic [1:0] htrans, kind;
    logic hwrite, hreadyout, hresp, irq_pin, sts_pin, pending, inserted, glitch_b;
    logic [3:0] caps, volt_caps;
    logic det_a, det_b, cardbus, legacy16, irq_out, pwr_on, pwr_auto;
    int bad_count, n_checks;

    sspf_socket_regs #(.PROBE_CYCLES(PROBE)) DUT (
        .hclk(hclk), .hresetn(hresetn), .global_reset_n(global_reset_n),
        .wake_event_enable(wake_event_enable), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .card_detect_a_pin(det_a), .card_detect_b_pin(det_b),
        .card_status_change_pin(sts_pin), .card_irq_pin(irq_pin),
        .probe_cardbus(cardbus), .probe_legacy16(legacy16), .probe_volt_caps(volt_caps),
        .removal_cycle_pending(pending), .socket_change_interrupt(irq_out),
        .socket_power_on(pwr_on), .socket_power_auto(pwr_auto)
    );

    sspf_card_model card (
        .inserted(inserted), .glitch_b(glitch_b), .kind(kind), .caps(caps),
        .detect_a_n(det_a), .detect_b_n(det_b), .cardbus(cardbus),
        .legacy16(legacy16), .volt_caps(volt_caps)
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Called just after a rising edge; returns just after the data phase edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic rdp();
        xfer(1'b0, `SSPF_PRESENT_OFS, 32'h0);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdp();
        chk(rd, 32'h6);
        xfer(1'b0, `SSPF_FORCE_OFS, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        $display("t_reset done");
    endtask

    task automatic t_pins();
        xfer(1'b1, `SSPF_MASK_OFS, 32'h1);
        irq_pin <= 1'b1;
        sts_pin <= 1'b1;
        cyc(3);
        rdp();
        chk(rd & 32'h41, 32'h41);
        chk({31'h0, irq_out}, 32'h1);
        xfer(1'b1, `SSPF_EVENT_OFS, 32'h1);
        cyc(2);
        chk({31'h0, irq_out}, 32'h0);
        irq_pin <= 1'b0;
        sts_pin <= 1'b0;
        cyc(2);
        rdp();
        chk(rd & 32'h41, 32'h0);
        $display("t_pins done");
    endtask

    task automatic t_insert();
        xfer(1'b1, `SSPF_MASK_OFS, 32'h6);
        kind <= 2'b10;
        caps <= 4'b0010;
        inserted <= 1'b1;
        cyc(2);
        rdp();
        v = rd;
        glitch_b <= 1'b1;
        cyc(1);
        rdp();
        chk(rd & 32'h6, v & 32'h6);
        glitch_b <= 1'b0;
        cyc(PROBE + 4);
        rdp();
        chk(rd & 32'h3FBE, 32'h820);
        chk({31'h0, irq_out}, 32'h1);
        xfer(1'b1, `SSPF_EVENT_OFS, 32'hF);
        $display("t_insert done");
    endtask

    task automatic t_reprobe();
        xfer(1'b1, `SSPF_FORCE_OFS, 32'h400);
        // Output flop lags the auto-power register by one edge
        cyc(2);
        chk({31'h0, pwr_auto}, 32'h0);
        kind <= 2'b00;
        xfer(1'b1, `SSPF_FORCE_OFS, 32'h4000);
        cyc(PROBE + 4);
        rdp();
        chk(rd & 32'hB0, 32'h80);
        chk({31'h0, pwr_auto}, 32'h1);
        kind <= 2'b01;
        xfer(1'b1, `SSPF_FORCE_OFS, 32'h4000);
        cyc(PROBE + 4);
        rdp();
        chk(rd & 32'h3CB0, 32'h810);
        $display("t_reprobe done");
    endtask

    task automatic t_supply();
        xfer(1'b1, `SSPF_CONTROL_OFS, 32'h40);
        cyc(1);
        rdp();
        chk(rd & 32'h208, 32'h200);
        xfer(1'b1, `SSPF_CONTROL_OFS, 32'h30);
        cyc(1);
        rdp();
        chk(rd & 32'h208, 32'h8);
        chk({31'h0, pwr_on}, 32'h1);
        xfer(1'b1, `SSPF_CONTROL_OFS, 32'h0);
        cyc(1);
        rdp();
        chk(rd & 32'h208, 32'h0);
        xfer(1'b1, `SSPF_EVENT_OFS, 32'hF);
        $display("t_supply done");
    endtask

    task automatic t_force();
        xfer(1'b1, `SSPF_FORCE_OFS, 32'h3FB0);
        rdp();
        chk(rd & 32'h3FB0, 32'h3FB0);
        chk({31'h0, pwr_auto}, 32'h0);
        xfer(1'b1, `SSPF_FORCE_OFS, 32'hF);
        rdp();
        chk(rd & 32'h3FBF, 32'h0);
        xfer(1'b0, `SSPF_EVENT_OFS, 32'h0);
        chk(rd & 32'hF, 32'hF);
        chk({31'h0, irq_out}, 32'h1);
        xfer(1'b1, `SSPF_EVENT_OFS, 32'hF);
        xfer(1'b1, `SSPF_FORCE_OFS, 32'h4000);
        cyc(PROBE + 4);
        $display("t_force done");
    endtask

    task automatic t_removal();
        xfer(1'b1, `SSPF_MASK_OFS, 32'h0);
        pending <= 1'b1;
        inserted <= 1'b0;
        cyc(3);
        rdp();
        chk(rd & 32'h106, 32'h106);
        chk({31'h0, irq_out}, 32'h0);
        pending <= 1'b0;
        $display("t_removal done");
    endtask

    // Socket empty here, so no interrogation follows a reset release
    task automatic t_ctx();
        // Enable settles first so the context reset cannot glitch low
        wake_event_enable <= 1'b1;
        cyc(1);
        hresetn <= 1'b0;
        cyc(2);
        hresetn <= 1'b1;
        cyc(1);
        rdp();
        chk(rd & 32'h100, 32'h100);
        wake_event_enable <= 1'b0;
        hresetn <= 1'b0;
        cyc(2);
        hresetn <= 1'b1;
        cyc(1);
        rdp();
        chk(rd & 32'h100, 32'h0);
        xfer(1'b1, `SSPF_FORCE_OFS, 32'h100);
        rdp();
        chk(rd & 32'h100, 32'h100);
        wake_event_enable <= 1'b1;
        global_reset_n <= 1'b0;
        cyc(2);
        global_reset_n <= 1'b1;
        cyc(1);
        rdp();
        chk(rd & 32'h100, 32'h0);
        $display("t_ctx done");
    endtask

    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end

    initial begin
        {hresetn, global_reset_n, wake_event_enable, hwrite, irq_pin} = 5'h0;
        {sts_pin, pending, inserted, glitch_b} = 4'h0;
        {haddr, hwdata, htrans, kind, caps} = '0;
        bad_count = 0;
        n_checks = 0;
        cyc(5);
        hresetn <= 1'b1;
        global_reset_n <= 1'b1;
        cyc(1);
        t_reset();
        t_pins();
        t_insert();
        t_reprobe();
        t_supply();
        t_force();
        t_removal();
        t_ctx();
        wrap_up();
    end
endmodule

`default_nettype wire
